// ==== design/pdw_pkg.sv ====
// package for the strap-configured watchdog and pd configuration block
// assumes a single 50 MHz system clock; strap levels are presented already decoded
`default_nettype none
package pdw_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WD_SHORT_S = 1;
  localparam int unsigned WD_LONG_S = 32;
  localparam int unsigned WD_SHORT_CYC = WD_SHORT_S * CLK_HZ;
  localparam longint unsigned WD_LONG_CYC = 64'(WD_LONG_S) * 64'(CLK_HZ);
  localparam int CNT_W = 32;
  localparam int ADDR_W = 3;
  localparam logic [CNT_W-1:0] TIMEOUT_RST = 32'hFFFFFFFF;
  // strap decode: low, capacitor, high
  typedef enum logic [1:0] {PDW_STRAP_LOW, PDW_STRAP_CAP, PDW_STRAP_HIGH} pdw_strap_e;
endpackage : pdw_pkg
`default_nettype wire

// ==== design/pdw_watchdog.sv ====
// watchdog, power-ok gating and pd strap configuration
// assumes all inputs synchronous to sys_clk_i; strap and mode levels valid at reset release
`default_nettype none
module pdw_watchdog (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic mode_pin_i,
  input wire logic sw_mode_i,
  input wire logic [1:0] watchdog_config_strap_i,
  input wire logic [2:0] addr_strap_i,
  input wire logic watchdog_kick_pin_i,
  input wire logic host_kick_i,
  input wire logic host_wd_enable_i,
  input wire logic timeout_wr_i,
  input wire logic [31:0] timeout_wdata_i,
  input wire logic voltages_ok_i,
  input wire logic local_power_detect_i,
  input wire logic class_valid_i,
  input wire logic detect_valid_i,
  input wire logic current_limit_select_i,
  output logic power_ok_out_o,
  output logic wd_timeout_o,
  output logic [31:0] timeout_reg_o,
  output logic local_power_detect_status_o,
  output logic local_power_run_o,
  output logic pd_enable_o,
  output logic class_resistor_pin_o,
  output logic signature_resistor_pin_o,
  output logic high_current_limit_o,
  output logic low_current_limit_o,
  output logic [2:0] i2c_addr_o,
  output logic reset_mode_o
);
  typedef enum logic [1:0] {PDW_ST_RESET, PDW_ST_OFF, PDW_ST_WAIT, PDW_ST_RUN} pdw_state_e;

  pdw_state_e state_ff;
  logic captured_ff;
  logic sw_ff;
  logic [1:0] strap_ff;
  logic kick_d_ff;
  logic [31:0] cnt_ff;
  logic [31:0] timeout_ff;
  logic timeout_flag_ff;
  logic kick;
  logic [31:0] load_val;

  assign kick = (watchdog_kick_pin_i != kick_d_ff) || host_kick_i;
  // the long period fits 32 bits, so the cut keeps every count bit
  assign load_val = !sw_ff ? ((strap_ff == 2'(pdw_pkg::PDW_STRAP_CAP)) ? 32'(pdw_pkg::WD_SHORT_CYC)
                    : 32'(pdw_pkg::WD_LONG_CYC)) : timeout_ff;

  // straps caught once, at the first edge after release
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      captured_ff <= 1'b0;
      sw_ff <= 1'b0;
      strap_ff <= 2'h0;
      i2c_addr_o <= 3'h0;
    end
    else if (!captured_ff)
    begin
      captured_ff <= 1'b1;
      sw_ff <= sw_mode_i;
      strap_ff <= watchdog_config_strap_i;
      i2c_addr_o <= addr_strap_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      kick_d_ff <= 1'b0;
    else
      kick_d_ff <= watchdog_kick_pin_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      timeout_ff <= pdw_pkg::TIMEOUT_RST;
    else if (sw_ff && timeout_wr_i && timeout_wdata_i != 32'h0)
      timeout_ff <= timeout_wdata_i;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= PDW_ST_RESET;
      cnt_ff <= pdw_pkg::TIMEOUT_RST;
      timeout_flag_ff <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        PDW_ST_RESET:
        begin
          if (captured_ff && mode_pin_i)
          begin
            if (strap_ff == 2'(pdw_pkg::PDW_STRAP_LOW) || strap_ff == 2'h3)
              state_ff <= PDW_ST_OFF;
            else
              state_ff <= PDW_ST_WAIT;
          end
        end
        PDW_ST_OFF:
          timeout_flag_ff <= 1'b0;
        PDW_ST_WAIT:
        begin
          cnt_ff <= load_val;
          if (!sw_ff && voltages_ok_i)
            state_ff <= PDW_ST_RUN;
          else if (sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_CAP) && voltages_ok_i)
            state_ff <= PDW_ST_RUN;
          else if (sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_HIGH) && host_wd_enable_i)
            state_ff <= PDW_ST_RUN;
        end
        PDW_ST_RUN:
        begin
          if (kick)
          begin
            cnt_ff <= load_val;
            timeout_flag_ff <= 1'b0;
          end
          else if (cnt_ff <= 32'h1)
          begin
            cnt_ff <= 32'h0;
            timeout_flag_ff <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff - 32'h1;
          if (sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_HIGH) && !host_wd_enable_i)
            state_ff <= PDW_ST_WAIT;
        end
      endcase
    end
  end

  // all outputs registered so the pins never glitch on decode
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      power_ok_out_o <= 1'b0;
      wd_timeout_o <= 1'b0;
      timeout_reg_o <= pdw_pkg::TIMEOUT_RST;
      local_power_detect_status_o <= 1'b0;
      local_power_run_o <= 1'b0;
      pd_enable_o <= 1'b0;
      class_resistor_pin_o <= 1'b1;
      signature_resistor_pin_o <= 1'b1;
      high_current_limit_o <= 1'b0;
      low_current_limit_o <= 1'b0;
      reset_mode_o <= 1'b1;
    end
    else
    begin
      power_ok_out_o <= voltages_ok_i && !timeout_flag_ff && state_ff != PDW_ST_RESET;
      wd_timeout_o <= timeout_flag_ff;
      timeout_reg_o <= timeout_ff;
      local_power_detect_status_o <= sw_ff && local_power_detect_i;
      local_power_run_o <= local_power_detect_i;
      pd_enable_o <= !local_power_detect_i;
      // resistors stay off once detached until reset; class stays on only in poe
      if (local_power_detect_i || class_valid_i)
        class_resistor_pin_o <= 1'b0;
      if (local_power_detect_i || detect_valid_i)
        signature_resistor_pin_o <= 1'b0;
      high_current_limit_o <= !local_power_detect_i && current_limit_select_i;
      low_current_limit_o <= !local_power_detect_i && !current_limit_select_i;
      reset_mode_o <= state_ff == PDW_ST_RESET;
    end
  end

  property p_timeout_drops_ok;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    timeout_flag_ff |=> !power_ok_out_o;
  endproperty
  a_timeout_drops_ok: assert property (p_timeout_drops_ok) else $error("power ok high during timeout");

  property p_kick_clears;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_RUN && kick) |=> (!timeout_flag_ff && cnt_ff == $past(load_val));
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("service did not reload");

  property p_off_no_timeout;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (captured_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_LOW)) |-> state_ff != PDW_ST_RUN;
  endproperty
  a_off_no_timeout: assert property (p_off_no_timeout) else $error("watchdog ran with strap low");

  property p_climit;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    local_power_detect_i |=> (!high_current_limit_o && !low_current_limit_o && !pd_enable_o);
  endproperty
  a_climit: assert property (p_climit) else $error("limit active in local power");

  property p_sig_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    detect_valid_i |=> !signature_resistor_pin_o;
  endproperty
  a_sig_off: assert property (p_sig_off) else $error("signature resistor still on");

  property p_cls_off;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    class_valid_i |=> !class_resistor_pin_o;
  endproperty
  a_cls_off: assert property (p_cls_off) else $error("class resistor still on");

  property p_reset_mode;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_RESET && !mode_pin_i) |=> state_ff == PDW_ST_RESET;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("left reset mode with mode low");

  property p_sw_wait;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_WAIT && sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_HIGH) && !host_wd_enable_i)
      |=> state_ff == PDW_ST_WAIT;
  endproperty
  a_sw_wait: assert property (p_sw_wait) else $error("watchdog started without enable");

  property p_edge_kick;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_RUN && $changed(watchdog_kick_pin_i)) |=> !timeout_flag_ff;
  endproperty
  a_edge_kick: assert property (p_edge_kick) else $error("pin edge not taken as service");

  // hardware periods are too long to run out in a bench, so the loaded count is watched instead
  property p_hw_short_load;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_WAIT && !sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_CAP))
      |=> cnt_ff == 32'(pdw_pkg::WD_SHORT_CYC);
  endproperty
  a_hw_short_load: assert property (p_hw_short_load) else $error("short hardware period not loaded");

  property p_hw_long_load;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (state_ff == PDW_ST_WAIT && !sw_ff && strap_ff == 2'(pdw_pkg::PDW_STRAP_HIGH))
      |=> cnt_ff == 32'(pdw_pkg::WD_LONG_CYC);
  endproperty
  a_hw_long_load: assert property (p_hw_long_load) else $error("long hardware period not loaded");
endmodule : pdw_watchdog
`default_nettype wire

// ==== dv/pdw_host_model.sv ====
// host model: services the watchdog by kick pin toggles or host commands
// assumes the bench sets enable and method on the same clock
`default_nettype none
module pdw_host_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic kick_en_i,
  input wire logic use_pin_i,
  output logic watchdog_kick_pin_o,
  output logic host_kick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tick_ff;
  // a kick every 16 cycles, well inside the shortest timeout the bench programs
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tick_ff <= 4'h0;
      watchdog_kick_pin_o <= 1'b0;
      host_kick_o <= 1'b0;
    end
    else
    begin
      tick_ff <= tick_ff + 4'h1;
      host_kick_o <= kick_en_i && !use_pin_i && tick_ff == 4'hF;
      if (kick_en_i && use_pin_i && tick_ff == 4'hF)
        watchdog_kick_pin_o <= !watchdog_kick_pin_o;
    end
  end
endmodule : pdw_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// bench for the watchdog and pd strap block, software mode with short timeouts
// assumes one 50 MHz clock; hardware one and 32 second periods are too long to run
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, mp, sw, ken, upin, kpin, hk, wen, twr, vok, local_power_detect, cv, dv, current_limit_select, seen;
  logic pok, wto, lds, lpr, pde, crp, srp, hcl, lcl, rmo;
  logic [31:0] treg, twd;
  logic [2:0] adr, ast;
  logic [1:0] strap;
  int errors, n_checks, cyc;
  pdw_host_model host_u (.sys_clk_i(clk), .rst_b_i(rst_b), .kick_en_i(ken), .use_pin_i(upin),
    .watchdog_kick_pin_o(kpin), .host_kick_o(hk));
  pdw_watchdog dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .mode_pin_i(mp), .sw_mode_i(sw),
    .watchdog_config_strap_i(strap), .addr_strap_i(ast), .watchdog_kick_pin_i(kpin), .host_kick_i(hk),
    .host_wd_enable_i(wen), .timeout_wr_i(twr), .timeout_wdata_i(twd), .voltages_ok_i(vok),
    .local_power_detect_i(local_power_detect), .class_valid_i(cv), .detect_valid_i(dv), .current_limit_select_i(current_limit_select),
    .power_ok_out_o(pok), .wd_timeout_o(wto), .timeout_reg_o(treg), .local_power_detect_status_o(lds),
    .local_power_run_o(lpr), .pd_enable_o(pde), .class_resistor_pin_o(crp), .signature_resistor_pin_o(srp),
    .high_current_limit_o(hcl), .low_current_limit_o(lcl), .i2c_addr_o(adr), .reset_mode_o(rmo));
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // runaway guard, the whole sequence needs about 1000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      stop_test();
    end
  end
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask : go
  task automatic do_reset(input logic m, input logic s, input logic [1:0] st);
    go(1);
    {rst_b, mp, sw, strap, ken, wen, vok, cv, dv, twr, local_power_detect} <= {1'b0, m, s, st, 7'h0};
    ast <= 3'($urandom);
    go(2);
    @(negedge clk);
    chk("timeout_reg_rst", treg, 32'hFFFFFFFF);
    go(1);
    rst_b <= 1'b1;
    go(4);
    @(negedge clk);
    chk("reset_mode", rmo, !m);
    chk("i2c_addr", adr, ast);
  endtask : do_reset
  task automatic wr_to(input logic [31:0] v);
    go(1);
    {twr, twd} <= {1'b1, v};
    go(1);
    twr <= 1'b0;
  endtask : wr_to
  task automatic quiet(input int n);
    seen = 0;
    repeat (n)
    begin
      @(negedge clk);
      seen |= wto;
    end
    chk("no_timeout", seen, 0);
    go(1);
  endtask : quiet
  task automatic wait_wto(input logic e);
    for (int i = 0; i < 120 && wto !== e; i++) @(negedge clk);
    chk("wd_timeout", wto, e);
    go(3);
    @(negedge clk);
    chk("power_ok", pok, !e);
    go(1);
  endtask : wait_wto
  initial
  begin
    {rst_b, mp, sw, strap, ast, ken, upin, wen, twr, twd, vok, local_power_detect, cv, dv, current_limit_select} = '0;
    void'($urandom(14));
    do_reset(0, 1, pdw_pkg::PDW_STRAP_CAP);
    $display("test reset_mode done");
    do_reset(1, 1, pdw_pkg::PDW_STRAP_CAP);
    // resistors are sticky, so each one is detached on its own with local power off
    go(1);
    cv <= 1'b1;
    go(1);
    cv <= 1'b0;
    go(2);
    @(negedge clk);
    chk("class_res", {crp, srp}, 2'h1);
    go(1);
    dv <= 1'b1;
    go(1);
    dv <= 1'b0;
    go(2);
    @(negedge clk);
    chk("sig_res", {crp, srp}, 2'h0);
    repeat (8)
    begin
      go(1);
      {local_power_detect, current_limit_select} <= 2'($urandom);
      go(3);
      @(negedge clk);
      chk("local_power_detect_status", lds, local_power_detect);
      chk("local_run", {lpr, pde}, {local_power_detect, !local_power_detect});
      if (!local_power_detect)
        chk("climit", {hcl, lcl}, {current_limit_select, !current_limit_select});
      else
        chk("climit_local", {hcl, lcl}, 2'h0);
    end
    go(1);
    {local_power_detect, cv, dv} <= 3'h6;
    go(1);
    {cv, dv} <= 2'h1;
    go(3);
    @(negedge clk);
    chk("resistors", {crp, srp}, 2'h0);
    $display("test strap_config done");
    wr_to(32'h28);
    go(2);
    @(negedge clk);
    chk("timeout_reg", treg, 32'h28);
    go(1);
    {vok, ken, upin} <= 3'h7;
    quiet(150);
    upin <= 1'b0;
    quiet(150);
    ken <= 1'b0;
    wait_wto(1);
    {ken, upin} <= 2'h3;
    wait_wto(0);
    vok <= 1'b0;
    go(3);
    @(negedge clk);
    chk("power_ok_volts", pok, 0);
    $display("test sw_watchdog done");
    do_reset(1, 1, pdw_pkg::PDW_STRAP_LOW);
    wr_to(32'h28);
    vok <= 1'b1;
    quiet(200);
    do_reset(1, 1, pdw_pkg::PDW_STRAP_HIGH);
    wr_to(32'h28);
    vok <= 1'b1;
    quiet(200);
    wen <= 1'b1;
    wait_wto(1);
    do_reset(1, 0, pdw_pkg::PDW_STRAP_CAP);
    wr_to(32'h28);
    go(2);
    @(negedge clk);
    chk("hw_write", treg, 32'hFFFFFFFF);
    do_reset(1, 0, pdw_pkg::PDW_STRAP_HIGH);
    go(1);
    vok <= 1'b1;
    quiet(100);
    $display("test strap_modes done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
